// ---- dv/fsl_lock_monitor.sv ----
// Purpose: port checker for fsl_lock
// Assumes: one clock, synchronous active-low reset
// Notes: grants other than part id are tied to the decoded levels
`timescale 1ns/10ps
`default_nettype none
module fsl_lock_monitor
    import fsl_pkg::*;
(
    // watched ports
    input wire logic CLK, RST_N, CHIP_ERASE, ARRAY_ERASE, EXT_ACCESS_N, FETCH_INTERNAL,
    input wire logic PAR_PROG_REQ, PAR_PROG_OK, PAR_VERIFY_REQ, PAR_VERIFY_OK,
    input wire logic PAR_ID_REQ, PAR_ID_OK, ISP_PROG_REQ, ISP_PROG_OK, CODE_READ_INSTRUCTION_FROM_EXT,
    input wire logic ISP_VERIFY_REQ, ISP_VERIFY_OK, CODE_READ_INSTRUCTION_INT_REQ, CODE_READ_INSTRUCTION_INT_OK,
    input wire logic [1:0] HW_LEVEL, SW_LEVEL,
    input wire logic [7:0] HSB_OUT, SSB_OUT, SBV_OUT,
    input wire logic [15:0] BOOT_ADDR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_erase; CHIP_ERASE ##1 1'b1; endsequence
    AST_ERASE: assert property (s_erase |-> ARRAY_ERASE && HSB_OUT == HSB_ERASED)
        else $error("erase did not clear the hardware byte");
    AST_ERASE_SBV: assert property (s_erase |-> SBV_OUT == SBV_DEFAULT)
        else $error("erase did not restore the boot vector");
    AST_ID: assert property (PAR_ID_OK == PAR_ID_REQ) else $error("id read refused");
    AST_PROG: assert property (PAR_PROG_OK == (PAR_PROG_REQ && HW_LEVEL == 2'h0))
        else $error("parallel program grant wrong");
    AST_VERIFY: assert property (PAR_VERIFY_OK == (PAR_VERIFY_REQ && HW_LEVEL < 2'h2))
        else $error("parallel verify grant wrong");
    AST_CODE_READ_INSTRUCTION: assert property (CODE_READ_INSTRUCTION_INT_OK ==
        (CODE_READ_INSTRUCTION_INT_REQ && !(CODE_READ_INSTRUCTION_FROM_EXT && HW_LEVEL != 0)))
        else $error("code read grant wrong");
    AST_ISP: assert property (ISP_PROG_OK == (ISP_PROG_REQ && SW_LEVEL == 2'h0))
        else $error("isp program grant wrong");
    AST_ISPV: assert property (ISP_VERIFY_OK == (ISP_VERIFY_REQ && SW_LEVEL < 2'h2))
        else $error("isp verify grant wrong");
    AST_FETCH: assert property (HW_LEVEL == 2'h3 |-> FETCH_INTERNAL)
        else $error("external execution not blocked");
    AST_FETCH_PIN: assert property (HW_LEVEL == 2'h0 |-> FETCH_INTERNAL == EXT_ACCESS_N)
        else $error("fetch source does not follow the pin");
    AST_EA_LATCH: assert property ((HW_LEVEL inside {2'h1, 2'h2}) && !CHIP_ERASE |=>
        $stable(FETCH_INTERNAL))
        else $error("latched fetch source moved");
    AST_HOLD: assert property (!CHIP_ERASE |=> $stable(HW_LEVEL))
        else $error("hardware level moved without erase");
    AST_RSVD: assert property (SSB_OUT[7:2] == 6'h3F) else $error("reserved bits cleared");
    AST_BOOT: assert property (BOOT_ADDR == (HSB_OUT[6] ? 16'h0000 : 16'hF800))
        else $error("boot address wrong");
endmodule
bind fsl_lock fsl_lock_monitor fsl_lock_monitor_inst (.*);
`default_nettype wire

// ---- dv/fsl_lock_tb_top.sv ----
// Purpose: self-checking bench for fsl_lock
// Assumes: 40 MHz clock, reset held 18 cycles at start, then 2 cycles per lock combination
// Notes: every lock combination, then writes and erase
`timescale 1ns/10ps
`default_nettype none
module fsl_lock_tb_top
    import fsl_pkg::*;
;
    logic CLK = 0, RST_N = 0, EXT_ACCESS_N = 1, CODE_READ_INSTRUCTION_FROM_EXT = 0, PAR_PROG_REQ = 0;
    logic PAR_VERIFY_REQ = 0, PAR_ID_REQ = 0, ISP_PROG_REQ = 0, ISP_VERIFY_REQ = 0, CODE_READ_INSTRUCTION_INT_REQ = 0;
    logic [7:0] HSB_NV = 0, SSB_NV = 0, h, s, b;
    logic [5:0] r;
    logic m, ea, pin;
    wire logic SSB_WR, BSB_WR, CHIP_ERASE, PAR_PROG_OK, PAR_VERIFY_OK, PAR_ID_OK, ISP_PROG_OK;
    wire logic ISP_VERIFY_OK, CODE_READ_INSTRUCTION_INT_OK, FETCH_INTERNAL, ARRAY_ERASE, DOUBLE_SPEED, EXPANDED_RAM_BIT_ENABLE;
    wire logic [1:0] HW_LEVEL, SW_LEVEL;
    wire logic [7:0] SSB_WDATA, BSB_WDATA, HSB_OUT, SSB_OUT, SBV_OUT, BSB_OUT;
    wire logic [15:0] BOOT_ADDR;
    wire logic [60:0] seen = {PAR_PROG_OK, PAR_VERIFY_OK, PAR_ID_OK, ISP_PROG_OK, ISP_VERIFY_OK,
        CODE_READ_INSTRUCTION_INT_OK, FETCH_INTERNAL, HW_LEVEL, SW_LEVEL, BOOT_ADDR, DOUBLE_SPEED, EXPANDED_RAM_BIT_ENABLE,
        HSB_OUT, SSB_OUT, SBV_OUT, BSB_OUT};
    logic [60:0] q[$];
    int miscompares = 0, checks = 0;
    always #12.5 CLK = ~CLK;
    fsl_lock fsl_lock_inst (.*);
    fsl_prog fsl_prog_inst (.*);
    function automatic logic [60:0] expv(logic [7:0] h, s, b, logic ea, p, m, logic [5:0] r);
        logic [1:0] hl, sl;
        hl = !h[2] ? 2'h3 : !h[1] ? 2'h2 : !h[0] ? 2'h1 : 2'h0;
        sl = !s[1] ? 2'h2 : !s[0] ? 2'h1 : 2'h0;
        return {r & {hl == 0, hl < 2, 1'b1, sl == 0, sl < 2, !(m && hl != 0)},
            (hl == 2'h3) || (hl == 2'h0 ? p : ea),
            hl, sl, h[6] ? BOOT_APP_ADDR : BOOT_LOADER_ADDR, !h[7], h[3], h,
            s | SSB_RSVD_MASK, SBV_DEFAULT, b};
    endfunction
    task automatic cmp(input logic [60:0] got, exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected outputs: expected %h seen %h", exp, got);
        end
    endtask
    task automatic expect_now;
        q.push_back(expv(h, s, b, ea, pin, m, r));
        @(posedge CLK);
    endtask
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(negedge CLK) if (q.size() > 0) cmp(seen, q.pop_front());
    initial begin
        h = 8'($urandom(32'h09AC));
        repeat (16) @(posedge CLK);
        for (int i = 0; i < 32; i++) begin
            {h, s, r, m, ea} = 24'($urandom);
            h[2:0] = i[2:0];
            s[1:0] = i[4:3];
            b = BSB_DEFAULT;
            pin = ea;
            RST_N <= 0;
            HSB_NV <= h;
            SSB_NV <= s;
            {PAR_PROG_REQ, PAR_VERIFY_REQ, PAR_ID_REQ, ISP_PROG_REQ, ISP_VERIFY_REQ, CODE_READ_INSTRUCTION_INT_REQ} <= r;
            CODE_READ_INSTRUCTION_FROM_EXT <= m;
            EXT_ACCESS_N <= ea;
            repeat (2) @(posedge CLK);
            RST_N <= 1;
            HSB_NV <= ~h;
            SSB_NV <= ~s;
            @(posedge CLK);
            expect_now;
            pin = !ea;
            EXT_ACCESS_N <= pin;
            expect_now;
        end
        fsl_prog_inst.strobe(1, BSB_APP);
        b = BSB_APP;
        expect_now;
        fsl_prog_inst.strobe(0, 8'hFE);
        s = s & 8'hFE;
        expect_now;
        fsl_prog_inst.strobe(0, 8'h00);
        s = 8'h00;
        expect_now;
        fsl_prog_inst.strobe(2, 8'h00);
        {h, s, b} = {HSB_ERASED, SSB_DEFAULT, BSB_DEFAULT};
        expect_now;
        complete_run;
    end
    initial begin
        repeat (5000) @(posedge CLK);
        miscompares++;
        complete_run;
    end
endmodule
`default_nettype wire

// ---- dv/fsl_prog.sv ----
// Purpose: programmer and isp firmware model
// Assumes: strobes launched just after a clock edge
// Notes: sel 0 software byte, 1 boot status, 2 chip erase
`timescale 1ns/10ps
`default_nettype none
module fsl_prog
    import fsl_pkg::*;
(
    input wire logic CLK,
    output logic SSB_WR, BSB_WR, CHIP_ERASE,
    output logic [7:0] SSB_WDATA, BSB_WDATA
);
    initial {SSB_WR, BSB_WR, CHIP_ERASE, SSB_WDATA, BSB_WDATA} = '0;
    task automatic strobe(input int sel, input logic [7:0] d);
        SSB_WDATA <= d | SSB_RSVD_MASK;
        BSB_WDATA <= d;
        {CHIP_ERASE, BSB_WR, SSB_WR} <= 3'h1 << sel;
        @(posedge CLK);
        {CHIP_ERASE, BSB_WR, SSB_WR} <= 3'h0;
        @(posedge CLK);
    endtask
endmodule
`default_nettype wire

// ---- hw/fsl_lock.sv ----
// Purpose: decodes hardware and software lock bits and gates flash access
// Assumes: fuse bytes presented by the nonvolatile array, sampled in reset
// Notes: chip erase returns both security bytes to their inactive state
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - three hardware lock bits decode to one of four parallel security levels
// - all hardware lock bits unprogrammed gives level 1, no protection
// - level 2 blocks internal code reads from external code, latches pin, blocks programming
// - level 2 still allows isp and application routine programming
// - bit1 programmed, bit2 not: level 2 plus parallel verify refused
// - bit2 programmed: level 3 plus external execution forbidden, factory default
// - hardware bits guard the parallel path, code reads from external code and external execution; isp governed by software byte
// - part identification readable in parallel modes at every level
// - factory hardware byte: jump bit and all three lock bits programmed, others unprogrammed, level four
// - software byte holds two lock bits; reserved bits 7 to 2 stay set
// - software bit0 programmed, bit1 not: isp programming refused
// - software bit1 programmed: isp programming and isp verify refused
// - external access pin high fetches internal, low fetches all externally
// - programmed jump bit boots loader at F800h, else application at 0000h
// - software boot vector defaults to FCh
module fsl_lock
    import fsl_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // nonvolatile fuse bytes
    input wire logic [7:0] HSB_NV,
    input wire logic [7:0] SSB_NV,
    // pins
    input wire logic EXT_ACCESS_N,
    // software byte writes from isp or api
    input wire logic SSB_WR,
    input wire logic [7:0] SSB_WDATA,
    input wire logic BSB_WR,
    input wire logic [7:0] BSB_WDATA,
    // chip erase from the parallel programmer
    input wire logic CHIP_ERASE,
    // access requests
    input wire logic PAR_PROG_REQ,
    input wire logic PAR_VERIFY_REQ,
    input wire logic PAR_ID_REQ,
    input wire logic ISP_PROG_REQ,
    input wire logic ISP_VERIFY_REQ,
    input wire logic CODE_READ_INSTRUCTION_INT_REQ,
    input wire logic CODE_READ_INSTRUCTION_FROM_EXT,
    // grants and state
    output logic PAR_PROG_OK,
    output logic PAR_VERIFY_OK,
    output logic PAR_ID_OK,
    output logic ISP_PROG_OK,
    output logic ISP_VERIFY_OK,
    output logic CODE_READ_INSTRUCTION_INT_OK,
    output logic FETCH_INTERNAL,
    output logic ARRAY_ERASE,
    output logic [1:0] HW_LEVEL,
    output logic [1:0] SW_LEVEL,
    output logic [7:0] HSB_OUT,
    output logic [7:0] SSB_OUT,
    output logic [7:0] SBV_OUT,
    output logic [7:0] BSB_OUT,
    output logic [15:0] BOOT_ADDR,
    output logic DOUBLE_SPEED,
    output logic EXPANDED_RAM_BIT_ENABLE
);
    logic [7:0] hardware_security_byte;
    logic [7:0] software_security_byte;
    logic [7:0] boot_status_byte;
    logic [7:0] software_boot_vector;
    logic ea_latched;
    logic erase_pulse;
    fsl_level_t hw_lvl;
    fsl_level_t sw_lvl;
    fsl_restrict_t rst_r;

    // fuse sampling in reset, erase afterwards
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            hardware_security_byte <= HSB_NV;
        end else if (CHIP_ERASE) begin
            hardware_security_byte <= HSB_ERASED;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            software_security_byte <= SSB_NV | SSB_RSVD_MASK;
        end else if (CHIP_ERASE) begin
            software_security_byte <= SSB_DEFAULT;
        end else if (SSB_WR) begin
            // bits may only be programmed further, reserved bits kept set
            software_security_byte <= software_security_byte & (SSB_WDATA | SSB_RSVD_MASK);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            boot_status_byte <= BSB_DEFAULT;
            software_boot_vector <= SBV_DEFAULT;
        end else if (CHIP_ERASE) begin
            boot_status_byte <= BSB_DEFAULT;
            software_boot_vector <= SBV_DEFAULT;
        end else if (BSB_WR && !rst_r.block_isp_prog) begin
            boot_status_byte <= BSB_WDATA;
        end
    end

    // external access pin latched in reset
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ea_latched <= EXT_ACCESS_N;
        end else begin
            ea_latched <= ea_latched;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            erase_pulse <= 1'b0;
        end else begin
            erase_pulse <= CHIP_ERASE;
        end
    end

    // hardware level decode, higher bits dominate
    always_comb begin
        if (!hardware_security_byte[HSB_LB2]) begin
            hw_lvl = FSL_LVL4;
        end else if (!hardware_security_byte[HSB_LB1]) begin
            hw_lvl = FSL_LVL3;
        end else if (!hardware_security_byte[HSB_LB0]) begin
            hw_lvl = FSL_LVL2;
        end else begin
            hw_lvl = FSL_LVL1;
        end
    end

    // software level decode
    always_comb begin
        if (!software_security_byte[SSB_LB1]) begin
            sw_lvl = FSL_LVL3;
        end else if (!software_security_byte[SSB_LB0]) begin
            sw_lvl = FSL_LVL2;
        end else begin
            sw_lvl = FSL_LVL1;
        end
    end

    always_comb begin
        rst_r.block_par_prog = (hw_lvl != FSL_LVL1);
        rst_r.block_par_verify = (hw_lvl == FSL_LVL3) || (hw_lvl == FSL_LVL4);
        rst_r.block_ext_exec = (hw_lvl == FSL_LVL4);
        rst_r.block_code_read_instruction_int = (hw_lvl != FSL_LVL1);
        rst_r.latch_ea = (hw_lvl != FSL_LVL1);
        rst_r.block_isp_prog = (sw_lvl != FSL_LVL1);
        rst_r.block_isp_verify = (sw_lvl == FSL_LVL3);
    end

    // grants; isp path ignores hardware level
    assign PAR_PROG_OK = PAR_PROG_REQ && !rst_r.block_par_prog;
    assign PAR_VERIFY_OK = PAR_VERIFY_REQ && !rst_r.block_par_verify;
    assign PAR_ID_OK = PAR_ID_REQ;
    assign ISP_PROG_OK = ISP_PROG_REQ && !rst_r.block_isp_prog;
    assign ISP_VERIFY_OK = ISP_VERIFY_REQ && !rst_r.block_isp_verify;
    assign CODE_READ_INSTRUCTION_INT_OK = CODE_READ_INSTRUCTION_INT_REQ && !(CODE_READ_INSTRUCTION_FROM_EXT && rst_r.block_code_read_instruction_int);

    // internal fetch when pin high; level 4 forbids external execution
    assign FETCH_INTERNAL = (rst_r.latch_ea ? ea_latched : EXT_ACCESS_N)
        || rst_r.block_ext_exec;

    assign ARRAY_ERASE = erase_pulse;
    assign HW_LEVEL = hw_lvl;
    assign SW_LEVEL = sw_lvl;
    assign HSB_OUT = hardware_security_byte;
    assign SSB_OUT = software_security_byte;
    assign SBV_OUT = software_boot_vector;
    assign BSB_OUT = boot_status_byte;
    assign BOOT_ADDR = hardware_security_byte[HSB_BOOT_LOADER_JUMP_BIT] ? BOOT_APP_ADDR
        : BOOT_LOADER_ADDR;
    assign DOUBLE_SPEED = !hardware_security_byte[HSB_X2];
    assign EXPANDED_RAM_BIT_ENABLE = hardware_security_byte[HSB_EXPANDED_RAM_BIT];
endmodule
`default_nettype wire

// ---- hw/fsl_pkg.sv ----
// Purpose: shared constants and types for the flash security lock logic
// Assumes: one core clock, synchronous reset
// Notes: security bits are active low, a programmed bit reads zero
package fsl_pkg;
    // hardware security byte field positions
    localparam int HSB_LB0 = 0;
    localparam int HSB_LB1 = 1;
    localparam int HSB_LB2 = 2;
    localparam int HSB_EXPANDED_RAM_BIT = 3;
    localparam int HSB_BOOT_LOADER_JUMP_BIT = 6;
    localparam int HSB_X2 = 7;
    // software security byte field positions
    localparam int SSB_LB0 = 0;
    localparam int SSB_LB1 = 1;
    // factory and erased values
    localparam logic [7:0] HSB_FACTORY = 8'hB8;
    localparam logic [7:0] HSB_ERASED = 8'hFF;
    localparam logic [7:0] SSB_DEFAULT = 8'hFF;
    localparam logic [7:0] SSB_RSVD_MASK = 8'hFC;
    localparam logic [7:0] SBV_DEFAULT = 8'hFC;
    localparam logic [7:0] BSB_DEFAULT = 8'hFF;
    localparam logic [7:0] BSB_APP = 8'h00;
    // boot addresses
    localparam logic [15:0] BOOT_LOADER_ADDR = 16'hF800;
    localparam logic [15:0] BOOT_APP_ADDR = 16'h0000;

    typedef enum logic [1:0] {FSL_LVL1, FSL_LVL2, FSL_LVL3, FSL_LVL4} fsl_level_t;

    // decoded access restrictions
    typedef struct packed {
        logic block_par_prog;
        logic block_par_verify;
        logic block_ext_exec;
        logic block_code_read_instruction_int;
        logic latch_ea;
        logic block_isp_prog;
        logic block_isp_verify;
    } fsl_restrict_t;
endpackage
